// ===== hw/socr_cfg.svh
`ifndef SOCR_CFG_SVH
`define SOCR_CFG_SVH
// How it works
// R1: DAC write marks channel feedback invalid
// R2: Blank length is settle plus filter plus four
// R3: Boost DAC write never starts blanking
// R4: Each channel uses its own filter length
// R5: Enable drives pin, else high impedance
// R6: Gain code picks 1.33, 2, 3, 5.33
// R7: Unity override forces gain 1.0
// R8: First probe: block1, block3, reference
// R9: Second probe: block2, block4, reference
// R10: Third probe: block5, block6, reference, supply
// R11: Core clock is system clock over value+1
// R12: System clock is 24 or 12 MHz
// R13: Host keeps divider fixed once cores run
// R14: Host should lock the divider register; no lock exists here, the divider stays writable
// R15: Divider value gates cores, flags, code RAM
// R16: Repeat DAC write restarts full blanking
`define SOCR_ADDR_SETTLE   10'h196
`define SOCR_ADDR_PROBE1   10'h197
`define SOCR_ADDR_PROBE2   10'h198
`define SOCR_ADDR_PROBE3   10'h199
`define SOCR_ADDR_DIVIDER  10'h1a0
`define SOCR_SETTLE_W      6
`define SOCR_DIV_W         6
`define SOCR_BLANK_OFFSET  10'h004
`define SOCR_EN_BIT        0
`define SOCR_GAIN_LSB      1
`define SOCR_SEL_LSB       3
`define SOCR_UNITY_BIT     6
`define SOCR_PROBE_W       7
`define SOCR_SEL_A         3'h0
`define SOCR_SEL_B         3'h1
`define SOCR_SEL_REF       3'h5
`define SOCR_SEL_SUPPLY    3'h7
`define SOCR_SRC_NONE      4'h0
`define SOCR_SRC_REF       4'h7
`define SOCR_SRC_SUPPLY    4'h8
`define SOCR_DIV_CORES     6'h01
`define SOCR_DIV_CRAM      6'h02
`endif

// ===== hw/socr_pkg.sv
package socr_pkg;
	// Analog gain selection presented to the probe amplifier
	typedef enum logic [2:0] {
		SOCR_GAIN_1P33 = 3'b000,
		SOCR_GAIN_2P0  = 3'b001,
		SOCR_GAIN_3P0  = 3'b010,
		SOCR_GAIN_5P33 = 3'b011,
		SOCR_GAIN_1P0  = 3'b100
	} socr_gain_t;
	typedef struct packed {
		logic       drive_enable;
		socr_gain_t gain;
		logic [3:0] source;
	} socr_probe_t;
	typedef struct packed {
		logic cores_allowed;
		logic flag_out_allowed;
		logic cram_read_allowed;
	} socr_mode_t;
endpackage : socr_pkg

// ===== hw/socr_top.sv
`include "socr_cfg.svh"
module socr_top #(
	parameter int NCH = 6,                                  // Current DAC channels
	parameter int FLW = 4                                   // Filter length width
) (
	input  wire logic                    clock_i,           // System clock
	input  wire logic                    rstn_i,            // Async reset, active low
	input  wire logic                    reg_wr_i,          // Register write strobe
	input  wire logic                    reg_rd_i,          // Register read strobe
	input  wire logic [9:0]              reg_addr_i,        // Register address
	input  wire logic [15:0]             reg_wdata_i,       // Write data
	output logic      [15:0]             reg_rdata_o,       // Read data, registered
	input  wire logic [NCH-1:0]          dac_wr_i,          // Current DAC written
	input  wire logic                    boost_dac_wr_i,    // Boost DAC written
	input  wire logic [NCH*FLW-1:0]      filter_len_i,      // Per-channel filter length
	output logic      [NCH-1:0]          feedback_valid_o,  // Feedback may be tested
	output socr_pkg::socr_probe_t        probe_first_pin_o, // First probe drive
	output socr_pkg::socr_probe_t        probe_second_pin_o,// Second probe drive
	output socr_pkg::socr_probe_t        probe_third_pin_o, // Third probe drive
	output logic                         microcore_clock_o, // Core clock enable pulse
	output socr_pkg::socr_mode_t         mode_o             // Allowed modes
);
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rstn;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rstn = rst_sync_reg[1];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [`SOCR_SETTLE_W-1:0] settle_reg, settle_next;
	logic [`SOCR_PROBE_W-1:0]  p1_reg, p1_next, p2_reg, p2_next, p3_reg, p3_next;
	logic [`SOCR_DIV_W-1:0]    div_reg, div_next;
	logic [15:0]               rdata_reg, rdata_next;

	always_comb begin
		settle_next = settle_reg;
		p1_next     = p1_reg;
		p2_next     = p2_reg;
		p3_next     = p3_reg;
		div_next    = div_reg;
		rdata_next  = rdata_reg;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`SOCR_ADDR_SETTLE:  settle_next = reg_wdata_i[`SOCR_SETTLE_W-1:0];
				`SOCR_ADDR_PROBE1:  p1_next     = reg_wdata_i[`SOCR_PROBE_W-1:0];
				`SOCR_ADDR_PROBE2:  p2_next     = reg_wdata_i[`SOCR_PROBE_W-1:0];
				`SOCR_ADDR_PROBE3:  p3_next     = reg_wdata_i[`SOCR_PROBE_W-1:0];
				// Host is trusted not to retune this once cores run
				`SOCR_ADDR_DIVIDER: div_next    = reg_wdata_i[`SOCR_DIV_W-1:0]; // R13
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`SOCR_ADDR_SETTLE:  rdata_next = {10'h000, settle_reg};
				`SOCR_ADDR_PROBE1:  rdata_next = {9'h000, p1_reg};
				`SOCR_ADDR_PROBE2:  rdata_next = {9'h000, p2_reg};
				`SOCR_ADDR_PROBE3:  rdata_next = {9'h000, p3_reg};
				`SOCR_ADDR_DIVIDER: rdata_next = {10'h000, div_reg};
				default:            rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn) begin
		if (!rstn) begin
			settle_reg <= '0;
			p1_reg     <= '0;
			p2_reg     <= '0;
			p3_reg     <= '0;
			div_reg    <= '0;
			rdata_reg  <= 16'h0000;
		end else begin
			settle_reg <= settle_next;
			p1_reg     <= p1_next;
			p2_reg     <= p2_next;
			p3_reg     <= p3_next;
			div_reg    <= div_next;
			rdata_reg  <= rdata_next;
		end
	end
	assign reg_rdata_o = rdata_reg;

	// ----------------------------------------
	// Settling blanking, one counter per channel
	// ----------------------------------------
	// Clock is 24 or 12 MHz; counts are in cycles so either rate works (R12)
	logic [NCH-1:0][9:0] blank_reg, blank_next;
	logic [NCH-1:0][9:0] blank_len;
	// boost_dac_wr_i has no path here, so it never blanks any feedback (R3)

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			blank_len[i] = 10'(settle_reg) + 10'(filter_len_i[i*FLW +: FLW])
				+ `SOCR_BLANK_OFFSET; // R2 R4
			// Reload rather than extend, so a repeat write always gives a full interval
			if (dac_wr_i[i]) begin
				blank_next[i] = blank_len[i]; // R1 R16
			end else if (blank_reg[i] != 10'h000) begin
				blank_next[i] = blank_reg[i] - 10'h001;
			end else begin
				blank_next[i] = blank_reg[i];
			end
			feedback_valid_o[i] = (blank_reg[i] == 10'h000); // R1
		end
	end

	always_ff @(posedge clock_i or negedge rstn) begin
		if (!rstn) begin
			blank_reg <= '0;
		end else begin
			blank_reg <= blank_next;
		end
	end

	// ----------------------------------------
	// Probe outputs
	// ----------------------------------------
	function automatic socr_pkg::socr_gain_t gain_of(input logic [`SOCR_PROBE_W-1:0] c);
		socr_pkg::socr_gain_t g;
		g = socr_pkg::socr_gain_t'({1'b0, c[`SOCR_GAIN_LSB +: 2]}); // R6
		if (c[`SOCR_UNITY_BIT]) begin
			g = socr_pkg::SOCR_GAIN_1P0; // R7
		end
		return g;
	endfunction : gain_of

	// Source code: 0 = nothing, 1..6 = measurement block, 7 = reference, 8 = supply
	function automatic logic [3:0] src_of(input logic [2:0] sel, input logic [3:0] blk_a,
		input logic [3:0] blk_b, input logic third);
		logic [3:0] s;
		s = `SOCR_SRC_NONE;
		case (sel)
			`SOCR_SEL_A:   s = blk_a;
			`SOCR_SEL_B:   s = blk_b;
			`SOCR_SEL_REF: s = `SOCR_SRC_REF;
			`SOCR_SEL_SUPPLY: s = third ? `SOCR_SRC_SUPPLY : `SOCR_SRC_NONE; // R10
			default:       s = `SOCR_SRC_NONE;
		endcase
		return s;
	endfunction : src_of

	socr_pkg::socr_probe_t pr1_reg, pr2_reg, pr3_reg, pr1_next, pr2_next, pr3_next;
	always_comb begin
		// Pin goes high impedance when enable is clear so probes share one ADC
		pr1_next.drive_enable = p1_reg[`SOCR_EN_BIT]; // R5
		pr2_next.drive_enable = p2_reg[`SOCR_EN_BIT]; // R5
		pr3_next.drive_enable = p3_reg[`SOCR_EN_BIT]; // R5
		pr1_next.gain = gain_of(p1_reg);
		pr2_next.gain = gain_of(p2_reg);
		pr3_next.gain = gain_of(p3_reg);
		pr1_next.source = src_of(p1_reg[`SOCR_SEL_LSB +: 3], 4'h1, 4'h3, 1'b0); // R8
		pr2_next.source = src_of(p2_reg[`SOCR_SEL_LSB +: 3], 4'h2, 4'h4, 1'b0); // R9
		pr3_next.source = src_of(p3_reg[`SOCR_SEL_LSB +: 3], 4'h5, 4'h6, 1'b1); // R10
	end
	// Supply has a code of its own, so it is never mistaken for block 6

	always_ff @(posedge clock_i or negedge rstn) begin
		if (!rstn) begin
			pr1_reg <= '0;
			pr2_reg <= '0;
			pr3_reg <= '0;
		end else begin
			pr1_reg <= pr1_next;
			pr2_reg <= pr2_next;
			pr3_reg <= pr3_next;
		end
	end
	assign probe_first_pin_o  = pr1_reg;
	assign probe_second_pin_o = pr2_reg;
	assign probe_third_pin_o  = pr3_reg;

	// ----------------------------------------
	// Core clock divider and mode gating
	// ----------------------------------------
	logic [`SOCR_DIV_W-1:0] dcnt_reg, dcnt_next;
	logic                   tick_reg, tick_next;
	socr_pkg::socr_mode_t   mode_reg, mode_next;

	always_comb begin
		tick_next = 1'b0;
		dcnt_next = dcnt_reg + 6'h01;
		// A zero divider parks the count at zero and never issues a tick
		if (dcnt_reg >= div_reg) begin
			dcnt_next = 6'h00;
			tick_next = (div_reg >= `SOCR_DIV_CORES); // R11 R15
		end
		mode_next.cores_allowed     = (div_reg >= `SOCR_DIV_CORES); // R15
		mode_next.flag_out_allowed  = (div_reg >= `SOCR_DIV_CORES); // R15
		mode_next.cram_read_allowed = (div_reg >= `SOCR_DIV_CRAM);  // R15
	end

	always_ff @(posedge clock_i or negedge rstn) begin
		if (!rstn) begin
			dcnt_reg <= '0;
			tick_reg <= 1'b0;
			mode_reg <= '0;
		end else begin
			dcnt_reg <= dcnt_next;
			tick_reg <= tick_next;
			mode_reg <= mode_next;
		end
	end
	assign microcore_clock_o = tick_reg;
	assign mode_o            = mode_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_blank_start: assert property (@(posedge clock_i) disable iff (!rstn) // R1
		dac_wr_i[0] |=> !feedback_valid_o[0])
		else $error("feedback valid right after DAC write");
	a_blank_len: assert property (@(posedge clock_i) disable iff (!rstn) // R2
		dac_wr_i[0] |=> blank_reg[0] == 10'($past(settle_reg))
			+ 10'($past(filter_len_i[FLW-1:0])) + `SOCR_BLANK_OFFSET)
		else $error("blank length wrong");
	a_blank_restart: assert property (@(posedge clock_i) disable iff (!rstn) // R16
		(dac_wr_i[0] && blank_reg[0] != 10'h000)
			|=> blank_reg[0] == 10'($past(settle_reg))
			+ 10'($past(filter_len_i[FLW-1:0])) + `SOCR_BLANK_OFFSET)
		else $error("blanking not restarted");
	a_boost_free: assert property (@(posedge clock_i) disable iff (!rstn) // R3
		(boost_dac_wr_i && dac_wr_i == '0 && feedback_valid_o == '1) |=> feedback_valid_o == '1)
		else $error("boost write blanked feedback");
	a_per_channel: assert property (@(posedge clock_i) disable iff (!rstn) // R4
		(dac_wr_i == 6'h01 && feedback_valid_o[1]) |=> feedback_valid_o[1])
		else $error("channel cross blanking");

	// ----------------------------------------
	// Probe checks
	// ----------------------------------------
	// Drive is registered, so every check looks one cycle after the config
	a_drive_en: assert property (@(posedge clock_i) disable iff (!rstn) // R5
		##1 pr1_reg.drive_enable == $past(p1_reg[`SOCR_EN_BIT]))
		else $error("drive enable mismatch");
	a_drive_second: assert property (@(posedge clock_i) disable iff (!rstn) // R5
		##1 pr2_reg.drive_enable == $past(p2_reg[`SOCR_EN_BIT]))
		else $error("second drive enable mismatch");
	a_drive_third: assert property (@(posedge clock_i) disable iff (!rstn) // R5
		##1 pr3_reg.drive_enable == $past(p3_reg[`SOCR_EN_BIT]))
		else $error("third drive enable mismatch");
	a_unity_gain: assert property (@(posedge clock_i) disable iff (!rstn) // R7
		p2_reg[`SOCR_UNITY_BIT] |=> pr2_reg.gain == socr_pkg::SOCR_GAIN_1P0)
		else $error("unity override ignored");
	a_gain_low: assert property (@(posedge clock_i) disable iff (!rstn) // R6
		(!p1_reg[`SOCR_UNITY_BIT] && p1_reg[`SOCR_GAIN_LSB +: 2] == 2'h0)
			|=> pr1_reg.gain == socr_pkg::SOCR_GAIN_1P33)
		else $error("gain code 0 wrong");
	a_gain_two: assert property (@(posedge clock_i) disable iff (!rstn) // R6
		(!p1_reg[`SOCR_UNITY_BIT] && p1_reg[`SOCR_GAIN_LSB +: 2] == 2'h1)
			|=> pr1_reg.gain == socr_pkg::SOCR_GAIN_2P0)
		else $error("gain code 1 wrong");
	a_gain_three: assert property (@(posedge clock_i) disable iff (!rstn) // R6
		(!p1_reg[`SOCR_UNITY_BIT] && p1_reg[`SOCR_GAIN_LSB +: 2] == 2'h2)
			|=> pr1_reg.gain == socr_pkg::SOCR_GAIN_3P0)
		else $error("gain code 2 wrong");
	a_gain_high: assert property (@(posedge clock_i) disable iff (!rstn) // R6
		(!p1_reg[`SOCR_UNITY_BIT] && p1_reg[`SOCR_GAIN_LSB +: 2] == 2'h3)
			|=> pr1_reg.gain == socr_pkg::SOCR_GAIN_5P33)
		else $error("gain code 3 wrong");
	a_first_src_a: assert property (@(posedge clock_i) disable iff (!rstn) // R8
		p1_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_A |=> pr1_reg.source == 4'h1)
		else $error("first probe block 1 not selected");
	a_first_src_b: assert property (@(posedge clock_i) disable iff (!rstn) // R8
		p1_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_B |=> pr1_reg.source == 4'h3)
		else $error("first probe block 3 not selected");
	a_first_ref: assert property (@(posedge clock_i) disable iff (!rstn) // R8
		p1_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_REF |=> pr1_reg.source == `SOCR_SRC_REF)
		else $error("first probe reference not selected");
	a_second_src_a: assert property (@(posedge clock_i) disable iff (!rstn) // R9
		p2_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_A |=> pr2_reg.source == 4'h2)
		else $error("second probe block 2 not selected");
	a_second_src_b: assert property (@(posedge clock_i) disable iff (!rstn) // R9
		p2_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_B |=> pr2_reg.source == 4'h4)
		else $error("second probe block 4 not selected");
	a_second_ref: assert property (@(posedge clock_i) disable iff (!rstn) // R9
		p2_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_REF |=> pr2_reg.source == `SOCR_SRC_REF)
		else $error("second probe reference not selected");
	a_third_src_a: assert property (@(posedge clock_i) disable iff (!rstn) // R10
		p3_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_A |=> pr3_reg.source == 4'h5)
		else $error("third probe block 5 not selected");
	a_third_src_b: assert property (@(posedge clock_i) disable iff (!rstn) // R10
		p3_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_B |=> pr3_reg.source == 4'h6)
		else $error("third probe block 6 not selected");
	a_third_supply: assert property (@(posedge clock_i) disable iff (!rstn) // R10
		p3_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_SUPPLY |=> pr3_reg.source == `SOCR_SRC_SUPPLY)
		else $error("third probe supply not selected");
	a_ref_sel: assert property (@(posedge clock_i) disable iff (!rstn) // R10
		p3_reg[`SOCR_SEL_LSB +: 3] == `SOCR_SEL_REF |=> pr3_reg.source == `SOCR_SRC_REF)
		else $error("reference not selected");

	// ----------------------------------------
	// Divider checks
	// ----------------------------------------
	a_div_zero: assert property (@(posedge clock_i) disable iff (!rstn) // R15
		(div_reg == 6'h00)[*2] |-> !microcore_clock_o && !mode_o.cores_allowed)
		else $error("cores allowed at divider zero");
	a_div_rate: assert property (@(posedge clock_i) disable iff (!rstn) // R11
		(microcore_clock_o && div_reg == 6'h01 && $stable(div_reg)) |=> !microcore_clock_o ##1 microcore_clock_o)
		else $error("divide by two wrong");
	a_cram_gate: assert property (@(posedge clock_i) disable iff (!rstn) // R15
		(div_reg >= `SOCR_DIV_CRAM) |=> mode_o.cram_read_allowed)
		else $error("code RAM read not allowed");
	a_cram_block: assert property (@(posedge clock_i) disable iff (!rstn) // R15
		(div_reg < `SOCR_DIV_CRAM) |=> !mode_o.cram_read_allowed)
		else $error("code RAM read allowed too early");
	a_cores_one: assert property (@(posedge clock_i) disable iff (!rstn) // R15
		(div_reg == `SOCR_DIV_CORES)
			|=> mode_o.cores_allowed && mode_o.flag_out_allowed)
		else $error("cores or flags blocked at divider one");
endmodule : socr_top

// ===== test/socr_host.sv
module socr_host (
	input  wire logic        clock_i, // System clock
	input  wire logic [15:0] rdata_i, // Read data
	output logic             wr_o,    // Write strobe
	output logic             rd_o,    // Read strobe
	output logic [9:0]       addr_o,  // Address
	output logic [15:0]      wdata_o, // Write data
	output logic [5:0]       dac_o,   // Current DAC writes
	output logic             boost_o, // Boost DAC write
	output logic [23:0]      flen_o   // Filter lengths
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Host register and DAC traffic
	// ----------------------------------------
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 10'h000;
		wdata_o = 16'h0000;
		dac_o = 6'h00;
		boost_o = 1'b0;
		flen_o = 24'h7777f0;
	end
	// Divider is rewritten only while no core timing is judged; no lock exists
	task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge clock_i);
		wr_o = w;
		rd_o = !w;
		addr_o = a;
		wdata_o = d;
		@(negedge clock_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		// Released lines flip so stale values never look valid
		addr_o = ~a;
		wdata_o = ~d;
		@(negedge clock_i);
		q = rdata_i;
	endtask : acc
	task automatic pulse(input logic [5:0] m, input logic b);
		@(negedge clock_i);
		dac_o = m;
		boost_o = b;
		@(negedge clock_i);
		dac_o = 6'h00;
		boost_o = 1'b0;
	endtask : pulse
endmodule : socr_host

// ===== test/socr_top_tb.sv
module socr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clock_i = 1'b0;
	logic                  rstn_i = 1'b0;
	logic                  wr, rd, bst, mclk;
	logic [9:0]            addr;
	logic [15:0]           wd, rdata, q;
	logic [5:0]            dac, valid;
	logic [23:0]           flen;
	socr_pkg::socr_probe_t pr [3];
	socr_pkg::socr_mode_t  mode;
	int                    err_count = 0;
	int                    cmp_count = 0;
	always #2.5 clock_i = ~clock_i;
	socr_host socr_host_inst (.clock_i(clock_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wd), .dac_o(dac), .boost_o(bst), .flen_o(flen));
	socr_top socr_top_inst (.clock_i(clock_i), .rstn_i(rstn_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .dac_wr_i(dac),
		.boost_dac_wr_i(bst), .filter_len_i(flen), .feedback_valid_o(valid),
		.probe_first_pin_o(pr[0]), .probe_second_pin_o(pr[1]), .probe_third_pin_o(pr[2]),
		.microcore_clock_o(mclk), .mode_o(mode));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic summarize;
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_word
	task automatic chk_count(input string n, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			err_count++;
			$display("[ERR] %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_count
	// Counts negedges with the channel blanked; a hang ends the run
	task automatic low_len(input int ch, output int n);
		n = 0;
		while (valid[ch] !== 1'b1) begin
			n++;
			if (n > 200) begin
				err_count++;
				summarize();
			end
			@(negedge clock_i);
		end
	endtask : low_len
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [9:0] a [6] = '{10'h196, 10'h197, 10'h198, 10'h199, 10'h1a0, 10'h19a};
		logic [15:0] m [6] = '{16'h003f, 16'h007f, 16'h007f, 16'h007f, 16'h003f, 16'h0000};
		chk_word("valid after reset", 16'h003f, {10'h000, valid});
		for (int i = 0; i < 6; i++) begin
			socr_host_inst.acc(1'b0, a[i], 16'h0000, q);
			chk_word("reset value", 16'h0000, q);
			socr_host_inst.acc(1'b1, a[i], 16'hffff, q);
			socr_host_inst.acc(1'b0, a[i], 16'h0000, q);
			chk_word("masked readback", m[i], q);
			socr_host_inst.acc(1'b1, a[i], 16'h0000, q);
		end
	endtask : t_regs
	task automatic t_probe;
		logic [2:0] sel [5] = '{3'h0, 3'h1, 3'h5, 3'h7, 3'h2};
		logic [3:0] src [3][5] = '{'{4'h1, 4'h3, 4'h7, 4'h0, 4'h0},
			'{4'h2, 4'h4, 4'h7, 4'h0, 4'h0}, '{4'h5, 4'h6, 4'h7, 4'h8, 4'h0}};
		socr_pkg::socr_probe_t e;
		for (int p = 0; p < 3; p++) begin
			for (int k = 0; k < 5; k++) begin
				socr_host_inst.acc(1'b1, 10'h197 + 10'(p), {9'h000, k == 4, sel[k], 2'(k), k[0]}, q);
				@(negedge clock_i);
				e.drive_enable = k[0];
				e.gain = (k == 4) ? socr_pkg::SOCR_GAIN_1P0 : socr_pkg::socr_gain_t'({1'b0, 2'(k)});
				e.source = src[p][k];
				chk_word("probe drive", {8'h00, e}, {8'h00, pr[p]});
			end
		end
	endtask : t_probe
	task automatic t_blank;
		int n;
		int st [3] = '{3, 3, 63};
		int ch [3] = '{0, 1, 1};
		int fl [3] = '{0, 15, 15};
		for (int i = 0; i < 3; i++) begin
			socr_host_inst.acc(1'b1, 10'h196, 16'(st[i]), q);
			socr_host_inst.pulse(6'(1 << ch[i]), 1'b0);
			low_len(ch[i], n);
			chk_count("blank length", st[i] + fl[i] + 4, n);
		end
		socr_host_inst.pulse(6'h00, 1'b1);
		chk_word("boost write", 16'h003f, {10'h000, valid});
		socr_host_inst.acc(1'b1, 10'h196, 16'h0003, q);
		socr_host_inst.pulse(6'h01, 1'b0);
		socr_host_inst.pulse(6'h01, 1'b0);
		low_len(0, n);
		chk_count("restart length", 7, n);
	endtask : t_blank
	task automatic t_div;
		logic [5:0] dv [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05};
		logic [2:0] md [5] = '{3'h0, 3'h6, 3'h7, 3'h7, 3'h7};
		int n;
		for (int i = 0; i < 5; i++) begin
			socr_host_inst.acc(1'b1, 10'h1a0, {10'h000, dv[i]}, q);
			@(negedge clock_i);
			chk_word("mode gates", {13'h0000, md[i]}, {13'h0000, mode});
			n = 0;
			while (mclk !== 1'b1 && n < 20) begin
				n++;
				@(negedge clock_i);
			end
			if (dv[i] == 6'h00) begin
				chk_count("idle core clock", 20, n);
			end else begin
				n = 0;
				do begin
					n++;
					@(negedge clock_i);
				end while (mclk !== 1'b1 && n < 80);
				chk_count("core clock period", int'(dv[i]) + 1, n);
			end
		end
	endtask : t_div
	initial begin
		repeat (3) @(negedge clock_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clock_i);
		t_regs();
		t_probe();
		t_blank();
		t_div();
		summarize();
	end
endmodule : socr_top_tb
